// File: verilog/rogc_regs.sv
`include "rogc_params.svh"
`default_nettype none
// Gain and output configuration register bank
module rogc_regs
  import rogc_pkg::*;
#(
  parameter logic [1:0] SILICON_REV = 2'h0 // Arbitrary value
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Configuration port, already decoded from the serial bus
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // Gain and channel controls
  output logic             analog_i_monitor_en,
  output logic             dual_channel_en,
  output logic      [11:0] agc_target_density,
  output rogc_gmode_t      gain_control_select,
  output logic      [5:0]  manual_pga_gain,
  output logic             pga_highpass_coupling_en,
  // Output stage controls
  output rogc_fmt_t        sample_fmt,
  output logic      [1:0]  sample_bits,
  output logic             adc_bypass,
  output logic             heavy_load_drive_en,
  output rogc_term_t       sdio_idle_termination,
  output logic             cfg_reserved
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [31:0] gain_output_config_q;
  logic [31:0] filter_gain_test_config_q;
  logic [31:0] rdata_d;
  logic [1:0]  sample_bits_d;
  rogc_fmt_t   sample_fmt_d;
  rogc_gmode_t gain_mode_d;
  logic        adc_bypass_d;
  logic        cfg_reserved_d;

  // Word one: whole word taken at once; revision bits never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_output_config_q <= `ROGC_RST_GAIN_OUT;
    end else if (cfg_wr && cfg_addr == `ROGC_ADDR_GAIN_OUT) begin
      gain_output_config_q <= {cfg_wdata[31:2], 2'h0}; // see R14 see R9 see R10
    end
  end

  // Word two: reserved bits kept as written so host read-back works
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filter_gain_test_config_q <= `ROGC_RST_FILT_GAIN;
    end else if (cfg_wr && cfg_addr == `ROGC_ADDR_FILT_GAIN) begin
      filter_gain_test_config_q <= cfg_wdata; // see R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    unique case (cfg_addr)
      `ROGC_ADDR_GAIN_OUT:  rdata_d = {gain_output_config_q[31:2], SILICON_REV}; // see R9
      `ROGC_ADDR_FILT_GAIN: rdata_d = filter_gain_test_config_q;
      default:              rdata_d = 32'h0;
    endcase
  end

  // Read data registered; one cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata  <= 32'h0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  rogc_decode u_decode (
    .res_code     (gain_output_config_q[`ROGC_RES_HI:`ROGC_RES_LO]),
    .fmt_code     (gain_output_config_q[`ROGC_FMT_HI:`ROGC_FMT_LO]),
    .gmode_code   (gain_output_config_q[`ROGC_GMODE_HI:`ROGC_GMODE_LO]),
    .drv_code     (gain_output_config_q[`ROGC_DRV_HI:`ROGC_DRV_LO]),
    .sample_bits  (sample_bits_d),
    .sample_fmt   (sample_fmt_d),
    .gain_mode    (gain_mode_d),
    .adc_bypass   (adc_bypass_d),
    .cfg_reserved (cfg_reserved_d)
  );

  // Plain field outputs straight from storage flops
  assign analog_i_monitor_en      = gain_output_config_q[`ROGC_MON_BIT];                  // see R1
  assign dual_channel_en          = gain_output_config_q[`ROGC_DUAL_BIT];                 // see R2
  assign agc_target_density       = gain_output_config_q[`ROGC_TGT_HI:`ROGC_TGT_LO];      // see R3
  assign sdio_idle_termination    = rogc_term_t'(gain_output_config_q[`ROGC_TERM_HI:`ROGC_TERM_LO]); // see R4
  assign manual_pga_gain          = filter_gain_test_config_q[`ROGC_MGAIN_HI:`ROGC_MGAIN_LO]; // see R11
  assign heavy_load_drive_en      = filter_gain_test_config_q[`ROGC_HLOAD_BIT];           // see R12
  assign pga_highpass_coupling_en = filter_gain_test_config_q[`ROGC_HPASS_BIT];           // see R13

  // Decoded controls registered; reserved gain code holds previous mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_bits         <= 2'h2;
      sample_fmt          <= ROGC_FMT_SIGNMAG;
      gain_control_select <= ROGC_GM_AUTO;
      adc_bypass          <= 1'b0;
      cfg_reserved        <= 1'b0;
    end else begin
      sample_bits  <= sample_bits_d;  // see R7
      sample_fmt   <= sample_fmt_d;   // see R6
      adc_bypass   <= adc_bypass_d;   // see R8
      cfg_reserved <= cfg_reserved_d;
      if (gain_mode_d != ROGC_GM_HOLD) begin
        gain_control_select <= gain_mode_d; // see R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  wire wr1 = cfg_wr && cfg_addr == `ROGC_ADDR_GAIN_OUT;
  wire wr2 = cfg_wr && cfg_addr == `ROGC_ADDR_FILT_GAIN;

  mon_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 |=> analog_i_monitor_en == $past(cfg_wdata[28])) else $error("monitor bit not applied"); // see R1
  dual_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 |=> dual_channel_en == $past(cfg_wdata[27])) else $error("channel enable not applied"); // see R2
  target_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 |=> agc_target_density == $past(cfg_wdata[26:15])) else $error("target not applied"); // see R3
  term_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 |=> sdio_idle_termination == $past(cfg_wdata[14:13])) else $error("termination not applied"); // see R4
  manual_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 && cfg_wdata[12:11] == 2'h2 |=> ##1 gain_control_select == ROGC_GM_MANUAL)
    else $error("manual gain mode not selected"); // see R5
  format_twos_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 && cfg_wdata[10] |=> ##1 sample_fmt == ROGC_FMT_TWOS) else $error("format decode wrong"); // see R6
  res_three_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 && cfg_wdata[8:6] == 3'h4 |=> ##1 sample_bits == 2'h3) else $error("resolution decode wrong"); // see R7
  bypass_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1 |=> ##1 adc_bypass == $past(cfg_wdata[5], 2)) else $error("bypass decode wrong"); // see R8
  rev_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_rvalid && $past(cfg_addr) == `ROGC_ADDR_GAIN_OUT |-> cfg_rdata[1:0] == SILICON_REV)
    else $error("revision bits changed"); // see R9
  gain_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr2 |=> manual_pga_gain == $past(cfg_wdata[27:22])) else $error("manual gain not applied"); // see R11
  hload_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr2 |=> heavy_load_drive_en == $past(cfg_wdata[20])) else $error("load drive not applied"); // see R12
  hpass_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wr2 |=> pga_highpass_coupling_en == $past(cfg_wdata[15])) else $error("coupling not applied"); // see R13
  readback_a: assert property (@(posedge clk) disable iff (!rstn)
    wr2 ##1 !cfg_wr ##1 (cfg_rd && cfg_addr == `ROGC_ADDR_FILT_GAIN && !cfg_wr) |=> cfg_rdata == $past(cfg_wdata, 3))
    else $error("read back mismatch"); // see R14

  manual_cov_c: cover property (@(posedge clk) disable iff (!rstn) gain_control_select == ROGC_GM_MANUAL);
  bypass_cov_c: cover property (@(posedge clk) disable iff (!rstn) adc_bypass && analog_i_monitor_en);
  read_cov_c:   cover property (@(posedge clk) disable iff (!rstn) wr1 ##1 cfg_rd);

endmodule : rogc_regs
`default_nettype wire

// File: verilog/rogc_params.svh
// Overview of operation
// R1: Monitor enable routes analog in-phase to pins
// R2: Channel enable: in-phase only, or both
// R3: Gain-control target, twelve bits, reset 170
// R4: Data pin idle termination code drives pad
// R5: Gain mode: automatic, manual, reserved codes
// R6: Sample format: unsigned, sign-magnitude, two's complement
// R7: Resolution codes give one, two, three bits
// R8: Driver select: CMOS, analog bypass, reserved
// R9: Revision bits read only, writes ignored
// R10: Host writes back reserved fields unchanged
// R11: Manual gain field, reset 0x3A, 1 dB steps
// R12: Heavy load drive enable bit
// R13: Highpass coupling enable, reset one
// R14: Fields apply after full word write
`ifndef ROGC_PARAMS_SVH
`define ROGC_PARAMS_SVH

// Register indices on the configuration port
`define ROGC_ADDR_GAIN_OUT     4'h1
`define ROGC_ADDR_FILT_GAIN    4'h2

// Word one field positions
`define ROGC_MON_BIT           28
`define ROGC_DUAL_BIT          27
`define ROGC_TGT_HI            26
`define ROGC_TGT_LO            15
`define ROGC_TERM_HI           14
`define ROGC_TERM_LO           13
`define ROGC_GMODE_HI          12
`define ROGC_GMODE_LO          11
`define ROGC_FMT_HI            10
`define ROGC_FMT_LO            9
`define ROGC_RES_HI            8
`define ROGC_RES_LO            6
`define ROGC_DRV_HI            5
`define ROGC_DRV_LO            4
`define ROGC_REV_HI            1
`define ROGC_REV_LO            0

// Word two field positions
`define ROGC_MGAIN_HI          27
`define ROGC_MGAIN_LO          22
`define ROGC_HLOAD_BIT         20
`define ROGC_HPASS_BIT         15

// Reset values of whole words (revision bits held zero in storage)
`define ROGC_RST_GAIN_OUT      32'h2055_0288
`define ROGC_RST_FILT_GAIN     32'h0eaf_a1dc
`define ROGC_RST_TGT           12'h0aa
`define ROGC_RST_MGAIN         6'h3a

`endif

// File: verilog/rogc_pkg.sv
`default_nettype none
package rogc_pkg;
  typedef enum logic [1:0] {ROGC_TERM_NONE, ROGC_TERM_PULLDN, ROGC_TERM_PULLUP, ROGC_TERM_HOLD} rogc_term_t;
  typedef enum logic [1:0] {ROGC_FMT_UNSIGNED, ROGC_FMT_SIGNMAG, ROGC_FMT_TWOS} rogc_fmt_t;
  typedef enum logic [1:0] {ROGC_GM_AUTO, ROGC_GM_MANUAL, ROGC_GM_HOLD} rogc_gmode_t;
endpackage : rogc_pkg
`default_nettype wire

// File: verilog/rogc_decode.sv
`include "rogc_params.svh"
`default_nettype none
// Turns raw word-one codes into datapath controls
module rogc_decode
  import rogc_pkg::*;
(
  // Raw fields
  input  wire logic [2:0] res_code,
  input  wire logic [1:0] fmt_code,
  input  wire logic [1:0] gmode_code,
  input  wire logic [1:0] drv_code,
  // Decoded controls
  output logic      [1:0] sample_bits,
  output rogc_fmt_t       sample_fmt,
  output rogc_gmode_t     gain_mode,
  output logic            adc_bypass,
  output logic            cfg_reserved
);
  // Resolution: 0->1 bit, 2->2 bits, 4->3 bits
  always_comb begin
    unique case (res_code)
      3'h0:    sample_bits = 2'h1; // see R7
      3'h2:    sample_bits = 2'h2;
      3'h4:    sample_bits = 2'h3;
      default: sample_bits = 2'h0;
    endcase
  end

  // Codes 2 and 3 both mean two's complement
  assign sample_fmt = (fmt_code == 2'h0) ? ROGC_FMT_UNSIGNED :
                      (fmt_code == 2'h1) ? ROGC_FMT_SIGNMAG : ROGC_FMT_TWOS; // see R6

  // Reserved gain codes keep the last gain mode rather than guess
  assign gain_mode  = (gmode_code == 2'h0) ? ROGC_GM_AUTO :
                      (gmode_code == 2'h2) ? ROGC_GM_MANUAL : ROGC_GM_HOLD; // see R5
  assign adc_bypass = drv_code[1]; // see R8

  // Any reserved code in use is flagged
  assign cfg_reserved = (sample_bits == 2'h0) || (gain_mode == ROGC_GM_HOLD) || (drv_code == 2'h1);
endmodule : rogc_decode
`default_nettype wire

// File: test/rogc_host_model.sv
`default_nettype none
// Host side of the configuration port
module rogc_host_model (
  // Clock
  input  wire logic        clk,
  // Configuration port
  output var  logic        cfg_wr,
  output var  logic        cfg_rd,
  output var  logic [3:0]  cfg_addr,
  output var  logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port idle until the first request
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 4'h0;
    cfg_wdata = 32'h0;
  end
  ////////////////////////////////////////
  // Reserved bits go back at reset value, never a guess
  function automatic logic [31:0] keep(input logic [3:0] a, input logic [31:0] d);
    if (a == 4'h1) return (d & ~32'he000_000c) | 32'h2000_0008;
    if (a == 4'h2) return (d & ~32'hf02f_41c0) | 32'h002f_01c0;
    return d;
  endfunction : keep
  // Held across the taking edge, then released with inverted lines
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d; // No stale word left on the bus
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
  endtask : rd
endmodule : rogc_host_model
`default_nettype wire

// File: test/tb_top.sv
`default_nettype none
// Register bank bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0]  REV  = 2'h2;          // Arbitrary revision code
  localparam logic [31:0] RST1 = 32'h2055_0288; // Word one after reset
  localparam logic [31:0] RST2 = 32'h0eaf_a1dc; // Word two after reset
  logic clk, rstn, cfg_wr, cfg_rd, cfg_rvalid, mon, dual, bypass, hload, hpass, rsvd;
  logic [3:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, seed, w1, w2;
  logic [11:0] tgt;
  logic [5:0]  mgain;
  logic [1:0]  sbits, gm_exp;
  rogc_pkg::rogc_gmode_t gsel;
  rogc_pkg::rogc_fmt_t   fmt;
  rogc_pkg::rogc_term_t  term;
  int          fails, checks;
  logic [31:0] exp_q[$];
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  rogc_host_model rogc_host_model_i (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata));
  rogc_regs #(.SILICON_REV(REV)) rogc_regs_i (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .analog_i_monitor_en(mon), .dual_channel_en(dual), .agc_target_density(tgt), .gain_control_select(gsel),
    .manual_pga_gain(mgain), .pga_highpass_coupling_en(hpass), .sample_fmt(fmt), .sample_bits(sbits),
    .adc_bypass(bypass), .heavy_load_drive_en(hload), .sdio_idle_termination(term), .cfg_reserved(rsvd));
  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0);
  endfunction : nxt
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // Outputs once decode has settled; reserved gain codes keep the last mode
  task automatic fields(input logic [31:0] a, input logic [31:0] b);
    logic [2:0] r;
    r = a[8:6];
    if (a[12:11] == 2'h0) gm_exp = 2'h0;
    else if (a[12:11] == 2'h2) gm_exp = 2'h1;
    repeat (2) @(negedge clk);
    chk("monitor", a[28], mon);
    chk("dual", a[27], dual);
    chk("target", a[26:15], tgt);
    chk("term", a[14:13], term);
    chk("gmode", gm_exp, gsel);
    chk("format", (a[10:9] == 2'h3) ? 2'h2 : a[10:9], fmt);
    chk("bits", (r == 3'h0) ? 2'h1 : (r == 3'h2) ? 2'h2 : (r == 3'h4) ? 2'h3 : 2'h0, sbits);
    chk("bypass", a[5], bypass);
    chk("rsvd", r[0] | (r == 3'h6) | a[11] | (a[5:4] == 2'h1), rsvd);
    chk("mgain", b[27:22], mgain);
    chk("hload", b[20], hload);
    chk("hpass", b[15], hpass);
  endtask : fields
  task automatic get(input logic [3:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    rogc_host_model_i.rd(a);
  endtask : get
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // Each read answer against the oldest note; looked at mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious", 32'h0, 32'h1);
      else chk("rdata", exp_q.pop_front(), cfg_rdata);
    end
  end
  // Run takes about a hundred and ten cycles; a hang is cut well past that
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    fails = 0;
    checks = 0;
    seed = 32'hd3b6;
    gm_exp = 2'h0;
    repeat (10) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    w1 = RST1;
    w2 = RST2;
    fields(w1, w2);
    get(4'h1, {w1[31:2], REV});
    get(4'h2, w2);
    $display("reset test done");
    // Every code of the term, gain mode, format, resolution and driver fields, other bits random
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      w1 = rogc_host_model_i.keep(4'h1, {seed[31:15], i[1:0], i[1:0], i[1:0], i[2:0], i[1:0], seed[3:0]});
      rogc_host_model_i.wr(4'h1, w1);
      fields(w1, w2);
      get(4'h1, {w1[31:2], REV});
    end
    $display("word one test done");
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      w2 = rogc_host_model_i.keep(4'h2, seed);
      rogc_host_model_i.wr(4'h2, w2);
      get(4'h2, w2);
      fields(w1, w2);
      get(4'h2, w2);
    end
    $display("word two test done");
    // Unmapped index: write lost, read empty, words untouched
    rogc_host_model_i.wr(4'h3, ~w1);
    get(4'h3, 32'h0);
    get(4'h1, {w1[31:2], REV});
    get(4'h2, w2);
    repeat (3) @(negedge clk);
    chk("pending", 32'h0, exp_q.size());
    $display("unmapped test done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
